// file: dibs_core_model.sv
`timescale 1ns/1ps
module dibs_core_model #(
	parameter int LOAD_CYCLES = 8
) (
	input wire logic hclk, // system clock
	input wire logic hresetn, // async reset, low
	input wire dibs_pkg::dibs_core_cmd_t core_cmd, // commands from the sequencer
	output logic running_app // application image running
);
	localparam int SECTOR_BYTES = (int'(dibs_pkg::FLASH_END) + 1) / dibs_pkg::FLASH_SECTORS;
	int cnt;
	logic target_ok;

	////////////////////////////////////////////////////////////////////////////////
	// a reload only starts from an image start sector; any other address is ignored
	always_comb
	begin
		if (core_cmd.app_not_factory_select)
			target_ok = (int'(core_cmd.boot_addr) == 128 * SECTOR_BYTES);
		else
			target_ok = (int'(core_cmd.boot_addr) == 0);
	end

	////////////////////////////////////////////////////////////////////////////////
	// power-up always loads the factory image; a reload takes LOAD_CYCLES
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			running_app <= 1'b0;
			cnt <= 0;
		end
		else if (core_cmd.reconfig && !core_cmd.reset && target_ok
			&& running_app != core_cmd.app_not_factory_select)
		begin
			if (cnt == LOAD_CYCLES - 1)
			begin
				running_app <= core_cmd.app_not_factory_select;
				cnt <= 0;
			end
			else
				cnt <= cnt + 1;
		end
		else
			cnt <= 0;
	end
endmodule

// file: dibs_irq.sv
`timescale 1ns/1ps
module dibs_irq (
	input wire logic hclk, // system clock
	input wire logic hresetn, // async reset, low
	input wire logic [dibs_pkg::IRQ_W-1:0] events, // event pulses
	input wire logic clear_wr, // write-one-to-clear strobe
	input wire logic mask_wr, // mask write strobe
	input wire logic [dibs_pkg::IRQ_W-1:0] wdata, // write data bits
	output logic [dibs_pkg::IRQ_W-1:0] status, // sticky status
	output logic [dibs_pkg::IRQ_W-1:0] mask, // enable mask
	output logic irq // level interrupt
);

	logic [dibs_pkg::IRQ_W-1:0] next_status;
	logic [dibs_pkg::IRQ_W-1:0] next_mask;
	logic next_irq;

	always_comb
	begin
		// a set in the clearing cycle survives
		next_status = (status & ~(clear_wr ? wdata : dibs_pkg::IRQ_NONE)) | events;
		next_mask = mask_wr ? wdata : mask;
		next_irq = |(next_status & next_mask);
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			status <= dibs_pkg::IRQ_NONE;
			mask <= dibs_pkg::IRQ_NONE;
			irq <= 1'b0;
		end
		else
		begin
			status <= next_status;
			mask <= next_mask;
			irq <= next_irq;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	set_wins_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(|events) |=> ((status & $past(events)) == $past(events)))
		else $error("event lost against clear");
	irq_level_a: assert property (@(posedge hclk) disable iff (!hresetn)
		irq == |(status & mask))
		else $error("interrupt level wrong");

endmodule

// file: dibs_pkg.sv
package dibs_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// timing
	localparam int CLK_HZ = 20000000;
	localparam int MS_PER_S = 1000;
	localparam int HALF_PERIOD_MS = 500;
	localparam int APP_SHOW_MS = 7000;
	localparam int HALF_CYCLES = CLK_HZ / MS_PER_S * HALF_PERIOD_MS;
	localparam int APP_SHOW_TICKS = APP_SHOW_MS / HALF_PERIOD_MS;
	localparam int TICK_CNT_W = 28;
	localparam int APP_CNT_W = 4;
	localparam logic [APP_CNT_W-1:0] APP_LAST_TICK = APP_CNT_W'(APP_SHOW_TICKS - 1);
	localparam logic [APP_CNT_W-1:0] APP_CNT_ZERO = 4'h0;

	////////////////////////////////////////////////////////////////////////////////
	// flash map, byte addresses
	localparam int ADDR_W = 25;
	localparam int FLASH_SECTORS = 512;
	localparam int SUBSECTORS_PER_SECTOR = 16;
	localparam logic [ADDR_W-1:0] FACTORY_START = 25'h0000000;
	localparam logic [ADDR_W-1:0] FACTORY_END = 25'h07fffff;
	localparam logic [ADDR_W-1:0] APP_START = 25'h0800000;
	localparam logic [ADDR_W-1:0] APP_END = 25'h0ffffff;
	localparam logic [ADDR_W-1:0] FLASH_END = 25'h1ffffff;

	////////////////////////////////////////////////////////////////////////////////
	// state codes shown on the leds
	localparam logic [2:0] CODE_RESET = 3'h0;
	localparam logic [2:0] CODE_RELEASE = 3'h1;
	localparam logic [2:0] CODE_IDLE = 3'h2;
	localparam logic [2:0] CODE_APP_SEL = 3'h3;
	localparam logic [2:0] CODE_ADDR = 3'h4;
	localparam logic [2:0] CODE_WDOG = 3'h5;
	localparam logic [2:0] CODE_RECONF = 3'h6;
	localparam logic [2:0] CODE_ERROR = 3'h7;
	localparam logic [2:0] LEDS_OFF = 3'h0;
	localparam logic [2:0] LEDS_ALL = 3'h7;

	typedef enum logic [9:0] {
		S_RESET = 10'h001,
		S_RELEASE = 10'h002,
		S_IDLE = 10'h004,
		S_APP_SEL = 10'h008,
		S_ADDR = 10'h010,
		S_WDOG = 10'h020,
		S_RECONF = 10'h040,
		S_APP = 10'h080,
		S_APP_BACK = 10'h100,
		S_ERROR = 10'h200
	} dibs_state_t;

	////////////////////////////////////////////////////////////////////////////////
	// carriers
	typedef struct packed {
		logic reset;
		logic app_not_factory_select;
		logic write_addr;
		logic wd_disable;
		logic reconfig;
		logic [ADDR_W-1:0] boot_addr;
	} dibs_core_cmd_t;

	typedef struct packed {
		logic heartbeat_led;
		logic [2:0] state_code_leds;
	} dibs_leds_t;

	////////////////////////////////////////////////////////////////////////////////
	// registers
	localparam int RA_W = 12;
	localparam logic [RA_W-1:0] REG_CTRL = 12'h000;
	localparam logic [RA_W-1:0] REG_STATUS = 12'h004;
	localparam logic [RA_W-1:0] REG_IRQ_STAT = 12'h008;
	localparam logic [RA_W-1:0] REG_IRQ_MASK = 12'h00c;
	localparam logic [RA_W-1:0] REG_BOOT_ADDR = 12'h010;
	localparam int CTRL_RUN = 0;
	localparam int CTRL_FORCE_ERR = 1;
	localparam logic [1:0] CTRL_RESET = 2'h1;
	localparam int ST_APP = 3;
	localparam int ST_ERR = 4;
	localparam int ST_HB = 5;
	localparam int IRQ_W = 3;
	localparam int IRQ_RECONF = 0;
	localparam int IRQ_ERROR = 1;
	localparam int IRQ_APP_DONE = 2;
	localparam logic [IRQ_W-1:0] IRQ_NONE = 3'h0;
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic HRESP_OKAY = 1'b0;
	localparam logic [31:0] WORD_ZERO = 32'h00000000;

endpackage

// file: dibs_tick.sv
`timescale 1ns/1ps
module dibs_tick #(
	parameter int CYCLES = dibs_pkg::HALF_CYCLES
) (
	input wire logic hclk, // system clock
	input wire logic hresetn, // async reset, low
	output logic tick // one-cycle pulse every CYCLES
);

	localparam logic [dibs_pkg::TICK_CNT_W-1:0] LAST = dibs_pkg::TICK_CNT_W'(CYCLES - 1);
	localparam logic [dibs_pkg::TICK_CNT_W-1:0] ONE = 28'h0000001;
	localparam logic [dibs_pkg::TICK_CNT_W-1:0] ZERO = 28'h0000000;

	logic [dibs_pkg::TICK_CNT_W-1:0] cnt;
	logic [dibs_pkg::TICK_CNT_W-1:0] next_cnt;
	logic next_tick;

	always_comb
	begin
		next_tick = (cnt == LAST);
		next_cnt = next_tick ? ZERO : cnt + ONE;
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			cnt <= ZERO;
			tick <= 1'b0;
		end
		else
		begin
			cnt <= next_cnt;
			tick <= next_tick;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	tick_spacing_a: assert property (@(posedge hclk) disable iff (!hresetn)
		tick |=> !tick)
		else $error("tick pulses back to back");

endmodule

// file: dibs_top.sv
`timescale 1ns/1ps
// Summary of operation
// - in code 000 the remote update core reset is held high
// - steps in order: release reset, idle, application select, address, watchdog off
// - code 110 requests reconfiguration into the application image
// - low three leds show the state code in the factory image
// - top led toggles as heartbeat until the application image runs
// - undefined codes go to error hold: only heartbeat blinks, others off
// - in the application image the three leds blink together about seven seconds
// - after that period the application image reconfigures back to factory
// - after power-up the factory image loads and the sequence starts there
// - factory image spans byte addresses 0000000 to 07fffff
// - application image spans 0800000 to 0ffffff; that start is written
// - all image addresses are byte addresses
module dibs_top #(
	parameter int HALF_CYCLES = dibs_pkg::HALF_CYCLES
) (
	input wire logic hclk, // system clock
	input wire logic hresetn, // async reset, low
	input wire logic hsel, // slave select
	input wire logic [31:0] haddr, // byte address
	input wire logic [1:0] htrans, // transfer type
	input wire logic hwrite, // write not read
	input wire logic [2:0] hsize, // transfer size
	input wire logic [31:0] hwdata, // write data
	input wire logic hready, // bus ready
	output logic hreadyout, // slave ready
	output logic hresp, // response, always okay
	output logic [31:0] hrdata, // read data
	input wire logic running_app, // core reports application image
	output dibs_pkg::dibs_core_cmd_t core_cmd, // commands to remote_update_core
	output dibs_pkg::dibs_leds_t leds, // status leds
	output logic irq // interrupt, high level
);

	function automatic logic [2:0] code_of(input dibs_pkg::dibs_state_t s);
		case (s)
			dibs_pkg::S_RESET: code_of = dibs_pkg::CODE_RESET;
			dibs_pkg::S_RELEASE: code_of = dibs_pkg::CODE_RELEASE;
			dibs_pkg::S_IDLE: code_of = dibs_pkg::CODE_IDLE;
			dibs_pkg::S_APP_SEL: code_of = dibs_pkg::CODE_APP_SEL;
			dibs_pkg::S_ADDR: code_of = dibs_pkg::CODE_ADDR;
			dibs_pkg::S_WDOG: code_of = dibs_pkg::CODE_WDOG;
			dibs_pkg::S_RECONF: code_of = dibs_pkg::CODE_RECONF;
			default: code_of = dibs_pkg::CODE_ERROR;
		endcase
	endfunction

	function automatic logic in_app(input dibs_pkg::dibs_state_t s);
		in_app = (s == dibs_pkg::S_APP) || (s == dibs_pkg::S_APP_BACK);
	endfunction

	logic tick;
	logic [dibs_pkg::IRQ_W-1:0] irq_status;
	logic [dibs_pkg::IRQ_W-1:0] irq_mask;

	dibs_tick #(
		.CYCLES(HALF_CYCLES)
	) u_tick (
		.hclk(hclk),
		.hresetn(hresetn),
		.tick(tick)
	);

	////////////////////////////////////////////////////////////////////////////////
	// ahb-lite slave, zero wait states
	logic dph_wr;
	logic [dibs_pkg::RA_W-1:0] dph_addr;
	logic [1:0] ctrl;
	logic next_dph_wr;
	logic [dibs_pkg::RA_W-1:0] next_dph_addr;
	logic [1:0] next_ctrl;
	logic [31:0] next_hrdata;
	logic [31:0] status_word;
	logic addr_phase;
	logic clear_wr;
	logic mask_wr;

	always_comb
	begin
		addr_phase = hsel && hready && (htrans == dibs_pkg::HTRANS_NONSEQ);
		next_dph_wr = addr_phase && hwrite;
		next_dph_addr = addr_phase ? haddr[dibs_pkg::RA_W-1:0] : dph_addr;
		next_ctrl = ctrl;
		clear_wr = 1'b0;
		mask_wr = 1'b0;
		if (dph_wr)
		begin
			case (dph_addr)
				dibs_pkg::REG_CTRL: next_ctrl = hwdata[1:0];
				dibs_pkg::REG_IRQ_STAT: clear_wr = 1'b1;
				dibs_pkg::REG_IRQ_MASK: mask_wr = 1'b1;
				default: next_ctrl = ctrl;
			endcase
		end
		next_hrdata = hrdata;
		if (addr_phase && !hwrite)
		begin
			// read data are latched in the address phase so hrdata is a flop
			case (haddr[dibs_pkg::RA_W-1:0])
				dibs_pkg::REG_CTRL: next_hrdata = {30'h0, ctrl};
				dibs_pkg::REG_STATUS: next_hrdata = status_word;
				dibs_pkg::REG_IRQ_STAT: next_hrdata = {29'h0, irq_status};
				dibs_pkg::REG_IRQ_MASK: next_hrdata = {29'h0, irq_mask};
				dibs_pkg::REG_BOOT_ADDR: next_hrdata = {7'h00, core_cmd.boot_addr};
				default: next_hrdata = dibs_pkg::WORD_ZERO;
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			dph_wr <= 1'b0;
			dph_addr <= dibs_pkg::REG_CTRL;
			ctrl <= dibs_pkg::CTRL_RESET;
			hrdata <= dibs_pkg::WORD_ZERO;
			hreadyout <= 1'b1;
			hresp <= dibs_pkg::HRESP_OKAY;
		end
		else
		begin
			dph_wr <= next_dph_wr;
			dph_addr <= next_dph_addr;
			ctrl <= next_ctrl;
			hrdata <= next_hrdata;
			hreadyout <= 1'b1;
			hresp <= dibs_pkg::HRESP_OKAY;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// boot sequencer
	dibs_pkg::dibs_state_t state;
	dibs_pkg::dibs_state_t next_state;
	logic [dibs_pkg::APP_CNT_W-1:0] app_cnt;
	logic [dibs_pkg::APP_CNT_W-1:0] next_app_cnt;
	logic app_phase;
	logic next_app_phase;
	logic step;
	logic force_err;
	logic [dibs_pkg::IRQ_W-1:0] events;

	always_comb
	begin
		step = tick && ctrl[dibs_pkg::CTRL_RUN];
		force_err = ctrl[dibs_pkg::CTRL_FORCE_ERR];
		next_state = state;
		next_app_cnt = app_cnt;
		case (state)
			dibs_pkg::S_RESET:
				if (running_app)
					next_state = dibs_pkg::S_APP;
				else if (step)
					next_state = dibs_pkg::S_RELEASE;
			dibs_pkg::S_RELEASE:
				if (step)
					next_state = dibs_pkg::S_IDLE;
			dibs_pkg::S_IDLE:
				if (step)
					next_state = dibs_pkg::S_APP_SEL;
			dibs_pkg::S_APP_SEL:
				if (step)
					next_state = dibs_pkg::S_ADDR;
			dibs_pkg::S_ADDR:
				if (step)
					next_state = dibs_pkg::S_WDOG;
			dibs_pkg::S_WDOG:
				if (step)
					next_state = dibs_pkg::S_RECONF;
			dibs_pkg::S_RECONF:
				// the real device reloads here; the core's image flag ends the wait
				if (running_app)
					next_state = dibs_pkg::S_APP;
			dibs_pkg::S_APP:
				if (tick)
				begin
					if (app_cnt == dibs_pkg::APP_LAST_TICK)
						next_state = dibs_pkg::S_APP_BACK;
					next_app_cnt = app_cnt + 4'h1;
				end
			dibs_pkg::S_APP_BACK:
				if (!running_app)
					next_state = dibs_pkg::S_RESET;
			dibs_pkg::S_ERROR:
				next_state = dibs_pkg::S_ERROR;
			default:
				next_state = dibs_pkg::S_ERROR;
		endcase
		if (force_err && !in_app(state))
			next_state = dibs_pkg::S_ERROR;
		if (next_state != dibs_pkg::S_APP)
			next_app_cnt = dibs_pkg::APP_CNT_ZERO;
		next_app_phase = in_app(next_state) && (tick ? !app_phase : app_phase);
		events = dibs_pkg::IRQ_NONE;
		events[dibs_pkg::IRQ_RECONF] = (next_state != state) &&
			((next_state == dibs_pkg::S_RECONF) || (next_state == dibs_pkg::S_APP_BACK));
		events[dibs_pkg::IRQ_ERROR] = (next_state == dibs_pkg::S_ERROR) &&
			(state != dibs_pkg::S_ERROR);
		events[dibs_pkg::IRQ_APP_DONE] = (next_state == dibs_pkg::S_APP_BACK) &&
			(state == dibs_pkg::S_APP);
	end

	////////////////////////////////////////////////////////////////////////////////
	// outputs, all from flops, decoded from the next state
	dibs_pkg::dibs_core_cmd_t next_cmd;
	dibs_pkg::dibs_leds_t next_leds;

	always_comb
	begin
		next_cmd = core_cmd;
		next_cmd.reset = (next_state == dibs_pkg::S_RESET);
		next_cmd.write_addr = (next_state == dibs_pkg::S_ADDR);
		next_cmd.reconfig = (next_state == dibs_pkg::S_RECONF) ||
			(next_state == dibs_pkg::S_APP_BACK);
		if (next_state == dibs_pkg::S_RESET)
		begin
			next_cmd.app_not_factory_select = 1'b0;
			next_cmd.wd_disable = 1'b0;
			next_cmd.boot_addr = dibs_pkg::FACTORY_START;
		end
		if (next_state == dibs_pkg::S_APP_SEL)
			next_cmd.app_not_factory_select = 1'b1;
		if (next_state == dibs_pkg::S_ADDR)
			next_cmd.boot_addr = dibs_pkg::APP_START;
		if (next_state == dibs_pkg::S_WDOG)
			next_cmd.wd_disable = 1'b1;
		if (next_state == dibs_pkg::S_APP_BACK)
		begin
			// back to the factory image at its own start
			next_cmd.app_not_factory_select = 1'b0;
			next_cmd.boot_addr = dibs_pkg::FACTORY_START;
		end
		next_leds.heartbeat_led = in_app(next_state) ? 1'b0 :
			(tick ? !leds.heartbeat_led : leds.heartbeat_led);
		if (next_state == dibs_pkg::S_ERROR)
			next_leds.state_code_leds = dibs_pkg::LEDS_OFF;
		else if (in_app(next_state))
			next_leds.state_code_leds = next_app_phase ? dibs_pkg::LEDS_ALL :
				dibs_pkg::LEDS_OFF;
		else
			next_leds.state_code_leds = code_of(next_state);
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			state <= dibs_pkg::S_RESET;
			app_cnt <= dibs_pkg::APP_CNT_ZERO;
			app_phase <= 1'b0;
			core_cmd <= '{reset: 1'b1, app_not_factory_select: 1'b0, write_addr: 1'b0,
				wd_disable: 1'b0, reconfig: 1'b0, boot_addr: dibs_pkg::FACTORY_START};
			leds <= '{heartbeat_led: 1'b0, state_code_leds: dibs_pkg::CODE_RESET};
		end
		else
		begin
			state <= next_state;
			app_cnt <= next_app_cnt;
			app_phase <= next_app_phase;
			core_cmd <= next_cmd;
			leds <= next_leds;
		end
	end

	always_comb
	begin
		status_word = dibs_pkg::WORD_ZERO;
		status_word[2:0] = code_of(state);
		status_word[dibs_pkg::ST_APP] = in_app(state);
		status_word[dibs_pkg::ST_ERR] = (state == dibs_pkg::S_ERROR);
		status_word[dibs_pkg::ST_HB] = leds.heartbeat_led;
	end

	dibs_irq u_irq (
		.hclk(hclk),
		.hresetn(hresetn),
		.events(events),
		.clear_wr(clear_wr),
		.mask_wr(mask_wr),
		.wdata(hwdata[dibs_pkg::IRQ_W-1:0]),
		.status(irq_status),
		.mask(irq_mask),
		.irq(irq)
	);

	////////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	core_reset_held_a: assert property (state == dibs_pkg::S_RESET |-> core_cmd.reset)
		else $error("core reset not held in reset state");
	app_addr_step_a: assert property ((state == dibs_pkg::S_APP_SEL) && step && !force_err
		|=> (state == dibs_pkg::S_ADDR) && core_cmd.write_addr &&
		(core_cmd.boot_addr == dibs_pkg::APP_START) && core_cmd.app_not_factory_select)
		else $error("address step wrong");
	wdog_step_a: assert property ((state == dibs_pkg::S_ADDR) && step && !force_err
		|=> (state == dibs_pkg::S_WDOG) && core_cmd.wd_disable && !core_cmd.write_addr)
		else $error("watchdog step wrong");
	reconf_request_a: assert property (state == dibs_pkg::S_RECONF
		|-> core_cmd.reconfig && core_cmd.app_not_factory_select &&
		(leds.state_code_leds == dibs_pkg::CODE_RECONF))
		else $error("reconfig request missing");
	code_leds_a: assert property (!in_app(state) && (state != dibs_pkg::S_ERROR)
		|-> leds.state_code_leds == code_of(state))
		else $error("state code leds wrong");
	heartbeat_toggle_a: assert property (tick && !in_app(next_state)
		|=> leds.heartbeat_led != $past(leds.heartbeat_led))
		else $error("heartbeat did not toggle");
	error_leds_a: assert property (state == dibs_pkg::S_ERROR
		|-> (leds.state_code_leds == dibs_pkg::LEDS_OFF) ##1 (state == dibs_pkg::S_ERROR))
		else $error("error hold broken");
	app_blink_a: assert property ((state == dibs_pkg::S_APP) && tick &&
		(app_cnt != dibs_pkg::APP_LAST_TICK)
		|=> (state == dibs_pkg::S_APP) && (leds.state_code_leds != $past(leds.state_code_leds)))
		else $error("application blink wrong");
	app_back_a: assert property ((state == dibs_pkg::S_APP) && tick &&
		(app_cnt == dibs_pkg::APP_LAST_TICK)
		|=> (state == dibs_pkg::S_APP_BACK) && core_cmd.reconfig &&
		!core_cmd.app_not_factory_select && (core_cmd.boot_addr == dibs_pkg::FACTORY_START))
		else $error("return to factory wrong");
	boot_start_a: assert property ((state == dibs_pkg::S_RESET) && !running_app && step
		&& !force_err |=> (state == dibs_pkg::S_RELEASE) && !core_cmd.reset)
		else $error("sequence did not start");

	reach_reconf_c: cover property (state == dibs_pkg::S_RECONF);
	reach_back_c: cover property (state == dibs_pkg::S_APP_BACK);
	reach_error_c: cover property (state == dibs_pkg::S_ERROR);
	irq_raised_c: cover property ($rose(irq));

endmodule

// file: test_dual_image_boot_sequencer.sv
`timescale 1ns/1ps
module test_dual_image_boot_sequencer;
	typedef struct packed {
		logic [2:0] code;
		dibs_pkg::dibs_core_cmd_t cmd;
		dibs_pkg::dibs_core_cmd_t care;
	} dibs_row_t;
	logic hclk, hresetn, hsel, hwrite, running_app, irq, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0] htrans;
	logic [2:0] hsize, prev;
	dibs_pkg::dibs_core_cmd_t core_cmd;
	dibs_pkg::dibs_leds_t leds;
	dibs_row_t rows [7];
	int bad_count, comparisons, n, tog, k;
	logic shape_ok;

	dibs_top #(.HALF_CYCLES(4)) dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.running_app(running_app), .core_cmd(core_cmd), .leds(leds), .irq(irq));
	dibs_core_model core_u (.hclk(hclk), .hresetn(hresetn), .core_cmd(core_cmd),
		.running_app(running_app));

	always #25 hclk = ~hclk;

	////////////////////////////////////////////////////////////////////////////////
	function automatic dibs_pkg::dibs_core_cmd_t mk(logic r, logic a, logic w, logic d,
		logic c, logic [24:0] b);
		return '{r, a, w, d, c, b};
	endfunction

	task automatic chk_val(input string name, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp)
		begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic chk_cmd(input string name, input dibs_pkg::dibs_core_cmd_t exp,
		input dibs_pkg::dibs_core_cmd_t care, input dibs_pkg::dibs_core_cmd_t got);
		comparisons++;
		if ((got & care) !== (exp & care))
		begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", name, exp & care, got & care);
		end
	endtask

	// single transfer, address phase held until hready, then data phase
	task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] wd);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= dibs_pkg::HTRANS_NONSEQ;
		haddr <= {20'h00000, a};
		hwrite <= wr;
		hsize <= 3'h2;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		if (wr)
			hwdata <= wd;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
		chk_val("hresp", 32'(dibs_pkg::HRESP_OKAY), 32'(hresp));
	endtask

	task automatic rd_chk(input string name, input logic [11:0] a, input logic [31:0] exp);
		bus(1'b0, a, dibs_pkg::WORD_ZERO);
		chk_val(name, exp, rd);
	endtask

	task automatic wait_code(input logic [2:0] c);
		for (k = 0; k < 40 && leds.state_code_leds !== c; k++)
			@(negedge hclk);
	endtask

	task complete_run;
		$display("mismatches %0d of %0d comparisons", bad_count, comparisons);
		if (bad_count == 0 && comparisons > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	initial
	begin
		repeat (20000) @(posedge hclk);
		bad_count++;
		complete_run;
	end

	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		hclk = 1'b0;
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = dibs_pkg::WORD_ZERO;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = dibs_pkg::WORD_ZERO;
		bad_count = 0;
		comparisons = 0;
		rows[0] = '{3'h0, mk(1, 0, 0, 0, 0, 0), mk(1, 1, 1, 1, 1, '1)};
		rows[1] = '{3'h1, mk(0, 0, 0, 0, 0, 0), mk(1, 0, 1, 0, 1, 0)};
		rows[2] = '{3'h2, mk(0, 0, 0, 0, 0, 0), mk(1, 0, 1, 0, 1, 0)};
		rows[3] = '{3'h3, mk(0, 1, 0, 0, 0, 0), mk(1, 1, 1, 0, 1, 0)};
		rows[4] = '{3'h4, mk(0, 0, 1, 0, 0, dibs_pkg::APP_START), mk(1, 0, 1, 0, 1, '1)};
		rows[5] = '{3'h5, mk(0, 0, 0, 1, 0, 0), mk(1, 0, 1, 1, 1, 0)};
		rows[6] = '{3'h6, mk(0, 1, 0, 0, 1, dibs_pkg::APP_START), mk(1, 1, 1, 0, 1, '1)};
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		@(negedge hclk);
		for (int i = 0; i < 7; i++)
		begin
			wait_code(rows[i].code);
			chk_cmd("core_cmd", rows[i].cmd, rows[i].care, core_cmd);
			chk_val("state leds", 32'(rows[i].code), 32'(leds.state_code_leds));
			chk_val("heartbeat", 32'(i[0]), 32'(leds.heartbeat_led));
		end
		for (k = 0; k < 100 && (running_app !== 1'b1 || core_cmd.reconfig !== 1'b0); k++)
			@(negedge hclk);
		// count the clock cycles and led toggles until the return request shows up
		n = 0;
		tog = 0;
		shape_ok = 1'b1;
		prev = leds.state_code_leds;
		while (n < 200)
		begin
			@(negedge hclk);
			if (core_cmd.reconfig === 1'b1 && core_cmd.app_not_factory_select === 1'b0)
				break;
			n++;
			if (leds.state_code_leds !== prev)
				tog++;
			prev = leds.state_code_leds;
			if (leds.heartbeat_led !== 1'b0 || (prev !== 3'h0 && prev !== 3'h7))
				shape_ok = 1'b0;
		end
		chk_val("app blink shape", 32'h1, 32'(shape_ok));
		chk_val("app span ok", 32'h1, 32'(n >= 52 && n <= 60));
		chk_val("app toggles ok", 32'h1, 32'(tog >= 12 && tog <= 15));
		chk_cmd("return cmd", mk(0, 0, 0, 0, 1, 0), mk(0, 1, 0, 0, 1, '1), core_cmd);
		for (k = 0; k < 100 && core_cmd.reset !== 1'b1; k++)
			@(negedge hclk);
		chk_val("core reset again", 32'h1, 32'(core_cmd.reset));
		wait_code(3'h1);
		chk_val("restart code", 32'h1, 32'(leds.state_code_leds));
		// stop stepping so no new events land while the interrupt logic is probed
		bus(1'b1, dibs_pkg::REG_CTRL, dibs_pkg::WORD_ZERO);
		@(negedge hclk);
		prev = leds.state_code_leds;
		n = leds.heartbeat_led;
		tog = 0;
		for (k = 0; k < 12; k++)
		begin
			@(negedge hclk);
			if (leds.heartbeat_led !== n[0])
				tog++;
			n = leds.heartbeat_led;
		end
		chk_val("frozen code", 32'(prev), 32'(leds.state_code_leds));
		chk_val("frozen heartbeat", 32'h1, 32'(tog >= 2));
		rd_chk("irq status", dibs_pkg::REG_IRQ_STAT, 32'h5);
		bus(1'b1, dibs_pkg::REG_IRQ_MASK, 32'h0);
		repeat (2) @(negedge hclk);
		chk_val("irq masked", 32'h0, 32'(irq));
		bus(1'b1, dibs_pkg::REG_IRQ_MASK, 32'h4);
		repeat (2) @(negedge hclk);
		chk_val("irq raised", 32'h1, 32'(irq));
		rd_chk("irq mask", dibs_pkg::REG_IRQ_MASK, 32'h4);
		bus(1'b1, dibs_pkg::REG_IRQ_STAT, 32'h5);
		repeat (2) @(negedge hclk);
		chk_val("irq cleared", 32'h0, 32'(irq));
		rd_chk("irq status clr", dibs_pkg::REG_IRQ_STAT, 32'h0);
		rd_chk("unmapped", 12'h100, 32'h0);
		// forced error: only the heartbeat keeps going
		bus(1'b1, dibs_pkg::REG_CTRL, 32'h3);
		repeat (2) @(negedge hclk);
		prev = 3'(leds.heartbeat_led);
		tog = 0;
		shape_ok = 1'b1;
		for (k = 0; k < 12; k++)
		begin
			@(negedge hclk);
			if (3'(leds.heartbeat_led) !== prev)
				tog++;
			prev = 3'(leds.heartbeat_led);
			if (leds.state_code_leds !== 3'h0)
				shape_ok = 1'b0;
		end
		chk_val("error leds off", 32'h1, 32'(shape_ok));
		chk_val("error heartbeat", 32'h1, 32'(tog >= 2));
		bus(1'b0, dibs_pkg::REG_STATUS, dibs_pkg::WORD_ZERO);
		chk_val("error flag", 32'h1, 32'(rd[dibs_pkg::ST_ERR]));
		rd_chk("irq status err", dibs_pkg::REG_IRQ_STAT, 32'h2);
		// reset in mid-run
		@(posedge hclk);
		hresetn <= 1'b0;
		@(negedge hclk);
		chk_val("leds in reset", 32'h0, 32'(leds));
		chk_val("core reset held", 32'h1, 32'(core_cmd.reset));
		@(posedge hclk);
		hresetn <= 1'b1;
		rd_chk("ctrl reset", dibs_pkg::REG_CTRL, 32'h1);
		rd_chk("boot addr reset", dibs_pkg::REG_BOOT_ADDR, 32'h0);
		wait_code(3'h1);
		chk_val("start after reset", 32'h1, 32'(leds.state_code_leds));
		complete_run;
	end
endmodule
